// ### common/lun_resv_defs.vh
`ifndef LUN_RESV_DEFS_VH
`define LUN_RESV_DEFS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_CTRL        8'h00
`define OFS_CDB_LO      8'h04
`define OFS_CDB_HI      8'h08
`define OFS_GO          8'h0C
`define OFS_RESULT      8'h10
`define OFS_STATE       8'h14

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_CTRL        32'h0000_0001
`define RST_WORD        32'h0000_0000

// ----------------------------------------
// Operation codes
// ----------------------------------------
`define OP_RESERVE      8'h16
`define OP_RELEASE      8'h17
`define OP_INQUIRY      8'h12
`define OP_REQ_SENSE    8'h03
`define OP_MEDIUM_LOCK  8'h1E

// ----------------------------------------
// Status bytes and sense keys
// ----------------------------------------
`define ST_GOOD         8'h00
`define ST_CHECK        8'h02
`define ST_CONFLICT     8'h18
`define SK_NONE         4'h0
`define SK_ILLEGAL      4'h5
`define SK_UNIT_ATTN    4'h6

// ----------------------------------------
// Command block fields, bytes 0..3 in CDB_LO
// ----------------------------------------
`define F_OPCODE        7:0
`define F_LUN           15:13
`define B_TP            12
`define F_TP_ID         11:9
`define B_EXTENT        8
`define F_RESV_ID       23:16

// ----------------------------------------
// Bytes 4..5 and initiator ID in CDB_HI
// ----------------------------------------
`define B_PREVENT       0
`define F_INIT_ID       18:16

// ----------------------------------------
// Control, result and state fields
// ----------------------------------------
`define B_CTRL_EXT_REL  0
`define F_RES_STATUS    7:0
`define F_RES_SENSE     11:8
`define B_RES_DONE      16
`define F_STATE_UA      23:16

`endif

// ### design/lun_reservation_control.v
// Summary of operation
// R1 - Release block: opcode 17h, byte1 fields, ID
// R2 - Reserve block: opcode 16h, list length bytes 3-4
// R3 - Only the creating initiator may release
// R4 - Foreign or void release: GOOD, nothing changed
// R5 - Unit release drops requester's non-third-party holds
// R6 - Unit release ignores reservation identifier
// R7 - Unsupported extent release: CHECK, ILLEGAL REQUEST
// R8 - Extent reservation implies extent release support
// R9 - Extent release drops only matching identifiers
// R10 - Third-party flag clear: no third-party release
// R11 - Third-party release needs same initiator, device
// R12 - Third-party release keeps mode parameters unchanged
// R13 - Unit reserve gives exclusive use until changed
// R14 - Unit held by another: RESERVATION CONFLICT
// R15 - Holder may reserve its own unit again
// R16 - Unit reserve ignores identifier and list length
// R17 - Others barred except four exempt commands
// R18 - Device reset clears holds, then UNIT ATTENTION
// R19 - Per-unit record of holder, flags, IDs
//
// Our own choices: the register offsets and the Avalon-MM register port.
`include "lun_resv_defs.vh"
`default_nettype none

module lun_reservation_control
#(
   parameter NUM_LUN  = 8,
   parameter NUM_INIT = 8
)
(
   input  wire               i_clk,
   input  wire               i_srst,
   input  wire               i_ce,
   input  wire [7:0]         i_avs_address,
   input  wire               i_avs_read,
   input  wire               i_avs_write,
   input  wire [31:0]        i_avs_writedata,
   input  wire [3:0]         i_avs_byteenable,
   output reg  [31:0]        o_avs_readdata,
   output wire               o_avs_waitrequest,
   input  wire               i_bus_dev_reset,
   output reg                o_cmd_done,
   output wire [NUM_LUN-1:0] o_reserved
);

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   reg  [31:0]           ctrl_reg;
   reg  [31:0]           cdb_lo_reg;
   reg  [31:0]           cdb_hi_reg;
   reg  [7:0]            status_reg;
   reg  [3:0]            sense_reg;
   reg                   done_reg;
   reg  [NUM_INIT-1:0]   ua_reg;
   reg  [NUM_INIT-1:0]   ua_next;
   reg                   ack_reg;
   reg                   rst_s1_reg;
   reg                   rst_s2_reg;
   reg                   rst_s3_reg;
   reg                   rst_lvl_reg;
   reg  [31:0]           rd_mux;
   reg  [7:0]            res_status;
   reg  [3:0]            res_sense;
   reg                   do_grant;
   reg                   do_cancel;
   wire                  bdr_event;
   wire                  wr_take;
   wire                  go;
   wire [2:0]            lun;
   wire                  lun_ok;
   wire [2:0]            lun_idx;
   wire [2:0]            init_id;
   wire [7:0]            opcode;
   wire                  cdb_ext;
   wire                  cdb_tp;
   wire [2:0]            cdb_tp_id;
   wire [7:0]            cdb_resv_id;
   wire                  ext_rel_en;
   wire [NUM_LUN-1:0]    rec_valid;
   wire [NUM_LUN*3-1:0]  rec_holder;
   wire [NUM_LUN-1:0]    rec_tp;
   wire [NUM_LUN*3-1:0]  rec_tp_id;
   wire [NUM_LUN*8-1:0]  rec_resv_id;
   wire [NUM_LUN-1:0]    rec_ext;
   wire                  sel_valid;
   wire [2:0]            sel_holder;
   wire                  sel_tp;
   wire [2:0]            sel_tp_id;
   wire [7:0]            sel_resv_id;
   wire                  sel_ext;
   wire [2:0]            sel_user;
   wire                  own_hold;
   wire                  tp_ok;
   wire                  exempt;
   wire [NUM_LUN-1:0]    grant_vec;
   wire [NUM_LUN-1:0]    cancel_vec;

   // ----------------------------------------
   // Byte-lane merge for register writes
   // ----------------------------------------
   function [31:0] be_merge;
      input [31:0] old_val;
      input [31:0] new_val;
      input [3:0]  be;
      integer      k;
      begin
         be_merge = old_val;
         for (k = 0; k < 4; k = k + 1)
         begin
            if (be[k])
            begin
               be_merge[k*8 +: 8] = new_val[k*8 +: 8];
            end
         end
      end
   endfunction

   // ----------------------------------------
   // Avalon slave handshake
   // ----------------------------------------

   // One wait cycle, answer at the second edge; clock enable low stalls
   assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~(ack_reg & i_ce);
   assign wr_take = i_avs_write & ack_reg & i_ce;
   assign go = wr_take && (i_avs_address == `OFS_GO);

   // Acknowledge toggle
   always @(posedge i_clk)
   begin
      if (i_srst)
      begin
         ack_reg <= 1'b0;
      end
      else if (i_ce)
      begin
         ack_reg <= (i_avs_read | i_avs_write) & ~ack_reg;
      end
   end

   // Read data mux, unmapped reads as zero
   always @*
   begin
      rd_mux = `RST_WORD;
      case (i_avs_address)
         `OFS_CTRL   : rd_mux = ctrl_reg;
         `OFS_CDB_LO : rd_mux = cdb_lo_reg;
         `OFS_CDB_HI : rd_mux = cdb_hi_reg;
         `OFS_RESULT :
         begin
            rd_mux[`F_RES_STATUS] = status_reg;
            rd_mux[`F_RES_SENSE]  = sense_reg;
            rd_mux[`B_RES_DONE]   = done_reg;
         end
         `OFS_STATE  :
         begin
            rd_mux[NUM_LUN-1:0] = rec_valid;
            rd_mux[`F_STATE_UA] = ua_reg;
         end
         default     : rd_mux = `RST_WORD;
      endcase
   end

   // Registered read data, captured in the wait cycle
   always @(posedge i_clk)
   begin
      if (i_srst)
      begin
         o_avs_readdata <= `RST_WORD;
      end
      else if (i_ce && i_avs_read && !ack_reg)
      begin
         o_avs_readdata <= rd_mux;
      end
   end

   // Writable registers
   always @(posedge i_clk)
   begin
      if (i_srst)
      begin
         ctrl_reg   <= `RST_CTRL;
         cdb_lo_reg <= `RST_WORD;
         cdb_hi_reg <= `RST_WORD;
      end
      else if (i_ce && wr_take)
      begin
         case (i_avs_address)
            `OFS_CTRL   :
               ctrl_reg <= be_merge(ctrl_reg, i_avs_writedata, i_avs_byteenable);
            `OFS_CDB_LO :
               cdb_lo_reg <= be_merge(cdb_lo_reg, i_avs_writedata, i_avs_byteenable);
            `OFS_CDB_HI :
               cdb_hi_reg <= be_merge(cdb_hi_reg, i_avs_writedata, i_avs_byteenable);
            default     : ;
         endcase
      end
   end

   // ----------------------------------------
   // Bus device reset input synchroniser
   // ----------------------------------------

   // Three stages; level changes once stages two and three agree
   always @(posedge i_clk)
   begin
      if (i_srst)
      begin
         rst_s1_reg  <= 1'b0;
         rst_s2_reg  <= 1'b0;
         rst_s3_reg  <= 1'b0;
         rst_lvl_reg <= 1'b0;
      end
      else if (i_ce)
      begin
         rst_s1_reg <= i_bus_dev_reset;
         rst_s2_reg <= rst_s1_reg;
         rst_s3_reg <= rst_s2_reg;
         if (rst_s2_reg == rst_s3_reg)
         begin
            rst_lvl_reg <= rst_s3_reg;
         end
      end
   end

   assign bdr_event = (rst_s2_reg == rst_s3_reg) & rst_s3_reg & ~rst_lvl_reg;

   // ----------------------------------------
   // Command block decode
   // ----------------------------------------
   assign opcode      = cdb_lo_reg[`F_OPCODE];           // R1
   assign lun         = cdb_lo_reg[`F_LUN];              // R1
   assign cdb_tp      = cdb_lo_reg[`B_TP];               // R1
   assign cdb_tp_id   = cdb_lo_reg[`F_TP_ID];            // R1
   assign cdb_ext     = cdb_lo_reg[`B_EXTENT];           // R2
   assign cdb_resv_id = cdb_lo_reg[`F_RESV_ID];          // R2
   assign init_id     = cdb_hi_reg[`F_INIT_ID];
   assign ext_rel_en  = ctrl_reg[`B_CTRL_EXT_REL];
   assign lun_ok      = ({29'h0, lun} < NUM_LUN);
   assign lun_idx     = lun_ok ? lun : 3'h0;

   // Addressed unit's record
   assign sel_valid   = rec_valid[lun_idx] & lun_ok;
   assign sel_holder  = rec_holder[lun_idx*3 +: 3];
   assign sel_tp      = rec_tp[lun_idx];
   assign sel_tp_id   = rec_tp_id[lun_idx*3 +: 3];
   assign sel_resv_id = rec_resv_id[lun_idx*8 +: 8];
   assign sel_ext     = rec_ext[lun_idx];

   // Device allowed to use a held unit
   assign sel_user = sel_tp ? sel_tp_id : sel_holder;

   // Requester made this hold
   assign own_hold = sel_valid && (sel_holder == init_id);   // R3

   // Third-party match for release
   assign tp_ok = cdb_tp ? (sel_tp && (sel_tp_id == cdb_tp_id)) // R11
                         : !sel_tp;                            // R10

   // Commands allowed past another's hold
   assign exempt = (opcode == `OP_INQUIRY)
                || (opcode == `OP_REQ_SENSE)
                || (opcode == `OP_RELEASE)
                || ((opcode == `OP_MEDIUM_LOCK)
                    && !cdb_hi_reg[`B_PREVENT]);             // R17

   // ----------------------------------------
   // Command evaluation
   // ----------------------------------------
   always @*
   begin
      res_status = `ST_GOOD;
      res_sense  = `SK_NONE;
      do_grant   = 1'b0;
      do_cancel  = 1'b0;
      if (ua_reg[init_id])
      begin
         res_status = `ST_CHECK;                            // R18
         res_sense  = `SK_UNIT_ATTN;                        // R18
      end
      else if (!lun_ok)
      begin
         res_status = `ST_CHECK;
         res_sense  = `SK_ILLEGAL;
      end
      else
      begin
         case (opcode)
            `OP_RELEASE :
            begin
               if (cdb_ext && !ext_rel_en)
               begin
                  res_status = `ST_CHECK;                   // R7
                  res_sense  = `SK_ILLEGAL;                 // R7
               end
               else if (cdb_ext)
               begin
                  // Only matching identifiers go
                  do_cancel = own_hold && sel_ext && tp_ok
                           && (sel_resv_id == cdb_resv_id); // R9
               end
               else
               begin
                  // Identifier byte not looked at
                  do_cancel = own_hold && tp_ok;            // R5 R6
               end
               // Other cases answer GOOD, nothing changed  // R4
            end
            `OP_RESERVE :
            begin
               if (cdb_ext)
               begin
                  // No extent reservation here
                  res_status = `ST_CHECK;                   // R8
                  res_sense  = `SK_ILLEGAL;
               end
               else if (sel_valid && (sel_holder != init_id))
               begin
                  res_status = `ST_CONFLICT;                // R14
               end
               else
               begin
                  do_grant = 1'b1;                          // R13 R15
               end
            end
            default :
            begin
               if (sel_valid && (sel_user != init_id) && !exempt)
               begin
                  res_status = `ST_CONFLICT;                // R17
               end
            end
         endcase
      end
   end

   // ----------------------------------------
   // Result register and completion pulse
   // ----------------------------------------
   always @(posedge i_clk)
   begin
      if (i_srst)
      begin
         status_reg <= `ST_GOOD;
         sense_reg  <= `SK_NONE;
         done_reg   <= 1'b0;
         o_cmd_done <= 1'b0;
      end
      else if (i_ce)
      begin
         o_cmd_done <= go;
         if (go)
         begin
            status_reg <= res_status;
            sense_reg  <= res_sense;
            done_reg   <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // Unit attention per initiator
   // ----------------------------------------

   // Reported command clears; reset event sets and wins
   always @*
   begin
      ua_next = ua_reg;
      if (go)
      begin
         ua_next[init_id] = 1'b0;
      end
      if (bdr_event)
      begin
         ua_next = {NUM_INIT{1'b1}};                       // R18
      end
   end

   // Hard reset leaves every initiator pending
   always @(posedge i_clk)
   begin
      if (i_srst)
      begin
         ua_reg <= {NUM_INIT{1'b1}};                       // R18
      end
      else if (i_ce)
      begin
         ua_reg <= ua_next;
      end
   end

   // ----------------------------------------
   // Per-unit reservation records
   // ----------------------------------------
   genvar g;
   generate
      for (g = 0; g < NUM_LUN; g = g + 1)
      begin : unit
         assign grant_vec[g]  = go && do_grant && (lun_idx == g);
         assign cancel_vec[g] = go && do_cancel && (lun_idx == g);

         // Identifier kept only for extent holds
         resv_record u_rec
         (
            .i_clk       (i_clk),
            .i_srst      (i_srst),
            .i_ce        (i_ce),
            .i_clear_all (bdr_event),                    // R18
            .i_grant     (grant_vec[g]),                 // R13
            .i_cancel    (cancel_vec[g]),                // R12
            .i_holder    (init_id),                      // R19
            .i_tp        (cdb_tp),
            .i_tp_id     (cdb_tp_id),
            .i_resv_id   (cdb_ext ? cdb_resv_id : 8'h00), // R16
            .i_ext       (cdb_ext),
            .o_valid     (rec_valid[g]),
            .o_holder    (rec_holder[g*3 +: 3]),
            .o_tp        (rec_tp[g]),
            .o_tp_id     (rec_tp_id[g*3 +: 3]),
            .o_resv_id   (rec_resv_id[g*8 +: 8]),
            .o_ext       (rec_ext[g])
         );
      end
   endgenerate

   // Reserved units for the outside
   assign o_reserved = rec_valid;

endmodule

`default_nettype wire

// ### design/resv_record.v
`default_nettype none

module resv_record
(
   input  wire       i_clk,
   input  wire       i_srst,
   input  wire       i_ce,
   input  wire       i_clear_all,
   input  wire       i_grant,
   input  wire       i_cancel,
   input  wire [2:0] i_holder,
   input  wire       i_tp,
   input  wire [2:0] i_tp_id,
   input  wire [7:0] i_resv_id,
   input  wire       i_ext,
   output reg        o_valid,
   output reg  [2:0] o_holder,
   output reg        o_tp,
   output reg  [2:0] o_tp_id,
   output reg  [7:0] o_resv_id,
   output reg        o_ext
);

   // ----------------------------------------
   // One unit's reservation record
   // ----------------------------------------

   // Clear wins over grant; fields kept on cancel
   always @(posedge i_clk)
   begin
      if (i_srst)
      begin
         o_valid   <= 1'b0;
         o_holder  <= 3'h0;
         o_tp      <= 1'b0;
         o_tp_id   <= 3'h0;
         o_resv_id <= 8'h00;
         o_ext     <= 1'b0;
      end
      else if (i_ce)
      begin
         if (i_clear_all || i_cancel)
         begin
            o_valid <= 1'b0; // R19
         end
         else if (i_grant)
         begin
            o_valid   <= 1'b1;
            o_holder  <= i_holder;
            o_tp      <= i_tp;
            o_tp_id   <= i_tp_id;
            o_resv_id <= i_resv_id;
            o_ext     <= i_ext;
         end
      end
   end

endmodule

`default_nettype wire

// ### test/host_initiator_model.sv
`default_nettype none

module host_initiator_model
(
   input  wire logic        i_clk,
   input  wire logic        i_waitrequest,
   input  wire logic [31:0] i_readdata,
   output var  logic [7:0]  o_address,
   output var  logic        o_read,
   output var  logic        o_write,
   output var  logic [31:0] o_writedata,
   output var  logic [3:0]  o_byteenable
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle bus at time zero
   initial
   begin
      o_address = 8'hFF;
      o_read = 1'b0;
      o_write = 1'b0;
      o_writedata = 32'h0;
      o_byteenable = 4'hF;
   end

   // One bus cycle, held until waitrequest is sampled low or 64 clocks pass
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic ok);
      ok = 1'b0;
      q = 32'h0;
      @(posedge i_clk);
      o_address <= a;
      o_write <= w;
      o_read <= !w;
      o_writedata <= d;
      for (int n = 0; n < 64 && !ok; n++)
      begin
         @(posedge i_clk);
         if (i_waitrequest === 1'b0)
         begin
            ok = 1'b1;
            q = i_readdata;
         end
      end
      o_read <= 1'b0;
      o_write <= 1'b0;
      o_address <= ~a;
      o_writedata <= ~d;
   endtask
endmodule

`default_nettype wire

// ### test/lun_reservation_control_monitor.sv
`include "lun_resv_defs.vh"
`default_nettype none

module lun_resv_monitor
#(
   parameter NUM_LUN = 8
)
(
   input wire logic               i_clk,
   input wire logic               i_srst,
   input wire logic               i_ce,
   input wire logic [7:0]         i_avs_address,
   input wire logic               i_avs_read,
   input wire logic               i_avs_write,
   input wire logic [31:0]        i_avs_writedata,
   input wire logic [3:0]         i_avs_byteenable,
   input wire logic [31:0]        o_avs_readdata,
   input wire logic               o_avs_waitrequest,
   input wire logic               i_bus_dev_reset,
   input wire logic               o_cmd_done,
   input wire logic [NUM_LUN-1:0] o_reserved
);
   timeunit 1ns;
   timeprecision 1ps;

   // ------------
   // Sequences
   // ------------
   default clocking mon_cb @(posedge i_clk);
   endclocking
   default disable iff (i_srst);

   // Command start write accepted on this edge
   wire logic go_take = i_avs_write && !o_avs_waitrequest && (i_avs_address == `OFS_GO);

   sequence req_wait_s;
      (i_avs_read || i_avs_write) && i_ce && o_avs_waitrequest;
   endsequence

   sequence go_take_s;
      go_take;
   endsequence

   property reset_clear_p;
      @(posedge i_clk) disable iff (1'b0)
      i_srst |=> (o_reserved == '0) && !o_cmd_done;
   endproperty

   // ------------
   // Assertions
   // ------------
   a_idle_no_wait: assert property (!(i_avs_read || i_avs_write) |-> !o_avs_waitrequest)
      else $error("waitrequest high with no request");
   a_one_wait_cycle: assert property (req_wait_s |=> !o_avs_waitrequest || !i_ce)
      else $error("request not acknowledged after one wait cycle");
   a_ce_stall_wait: assert property ((i_avs_read || i_avs_write) && !i_ce |-> o_avs_waitrequest)
      else $error("request acknowledged while clock enable low");
   a_done_after_go: assert property (go_take_s |=> o_cmd_done)
      else $error("no done pulse after command start");
   a_done_has_cause: assert property (o_cmd_done |-> $past(go_take || (o_cmd_done && !i_ce)))
      else $error("done pulse without command start");
   a_done_one_cycle: assert property (o_cmd_done && i_ce |=> !o_cmd_done)
      else $error("done pulse longer than one cycle");
   a_rdata_holds: assert property (!i_avs_read && !i_srst |=> $stable(o_avs_readdata))
      else $error("read data changed without a read");
   a_reset_clears: assert property (reset_clear_p)
      else $error("reset left a unit reserved");
   a_grant_needs_go: assert property (|(o_reserved & ~$past(o_reserved)) |-> $past(go_take))
      else $error("unit reserved without a command");
   a_bdr_clears: assert property ($rose(i_bus_dev_reset) |-> ##[1:6] (o_reserved == '0))
      else $error("bus device reset left a unit reserved");
endmodule

bind lun_reservation_control lun_resv_monitor #(.NUM_LUN(NUM_LUN)) lun_resv_monitor_inst
(
   .i_clk             (i_clk),
   .i_srst            (i_srst),
   .i_ce              (i_ce),
   .i_avs_address     (i_avs_address),
   .i_avs_read        (i_avs_read),
   .i_avs_write       (i_avs_write),
   .i_avs_writedata   (i_avs_writedata),
   .i_avs_byteenable  (i_avs_byteenable),
   .o_avs_readdata    (o_avs_readdata),
   .o_avs_waitrequest (o_avs_waitrequest),
   .i_bus_dev_reset   (i_bus_dev_reset),
   .o_cmd_done        (o_cmd_done),
   .o_reserved        (o_reserved)
);

`default_nettype wire

// ### test/lun_reservation_control_tb.sv
`include "lun_resv_defs.vh"
`default_nettype none

module lun_reservation_control_tb;
   timeunit 1ns;
   timeprecision 1ps;

   // ------------
   // Signals and model state
   // ------------
   logic        clk = 1'b0;
   logic        srst = 1'b1;
   logic        ce = 1'b1;
   logic        bdr = 1'b0;
   logic        rnd_ce = 1'b0;
   wire  [7:0]  avs_address;
   wire         avs_read;
   wire         avs_write;
   wire  [31:0] avs_writedata;
   wire  [3:0]  avs_byteenable;
   wire  [31:0] avs_readdata;
   wire         avs_waitrequest;
   wire         cmd_done;
   wire  [7:0]  reserved;
   int          fail_count = 0;
   int          n_tests = 0;
   int          seed = 32'h55411429;
   int          hold[8];
   int          tpid[8];
   bit          vld[8];
   bit          tpf[8];
   bit          ua[8] = '{default: 1'b1};
   bit          ext_en = 1'b1;
   logic [7:0]  ops[$] = '{`OP_RESERVE, `OP_RELEASE, `OP_INQUIRY, `OP_REQ_SENSE,
                           `OP_MEDIUM_LOCK, 8'h08};

   // Clock and random enable gaps
   always #2.5 clk = ~clk;
   always @(posedge clk)
      ce <= rnd_ce ? (($random(seed) & 3) != 0) : 1'b1;

   lun_reservation_control lun_reservation_control_inst
   (
      .i_clk(clk), .i_srst(srst), .i_ce(ce), .i_avs_address(avs_address),
      .i_avs_read(avs_read), .i_avs_write(avs_write), .i_avs_writedata(avs_writedata),
      .i_avs_byteenable(avs_byteenable), .o_avs_readdata(avs_readdata),
      .o_avs_waitrequest(avs_waitrequest), .i_bus_dev_reset(bdr),
      .o_cmd_done(cmd_done), .o_reserved(reserved)
   );

   host_initiator_model host_initiator_model_inst
   (
      .i_clk(clk), .i_waitrequest(avs_waitrequest), .i_readdata(avs_readdata),
      .o_address(avs_address), .o_read(avs_read), .o_write(avs_write),
      .o_writedata(avs_writedata), .o_byteenable(avs_byteenable)
   );

   // ------------
   // Tasks
   // ------------
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic close_out;
      $display("Checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      logic ok;
      host_initiator_model_inst.xfer(w, a, d, q, ok);
      if (!ok)
      begin
         fail_count++;
         close_out();
      end
   endtask

   // Model one command, run it, compare status and unit flags
   task automatic do_cmd(input int init, input logic [7:0] op, input logic [7:0] b1,
                         input logic [7:0] b2, input logic [7:0] b4);
      logic [31:0] q;
      logic [7:0]  ev;
      int          lun;
      int          st;
      int          sk;
      int          usr;
      lun = b1[7:5];
      st = `ST_GOOD;
      sk = `SK_NONE;
      usr = tpf[lun] ? tpid[lun] : hold[lun];
      if (ua[init])
      begin
         ua[init] = 1'b0;
         st = `ST_CHECK;
         sk = `SK_UNIT_ATTN;
      end
      else if ((op == `OP_RESERVE || op == `OP_RELEASE) && b1[0]
               && !(op == `OP_RELEASE && ext_en))
      begin
         st = `ST_CHECK;
         sk = `SK_ILLEGAL;
      end
      else if (op == `OP_RELEASE)
      begin
         if (!b1[0] && vld[lun] && hold[lun] == init && tpf[lun] == b1[4]
             && (!b1[4] || tpid[lun] == b1[3:1]))
            vld[lun] = 1'b0;
      end
      else if (op == `OP_RESERVE)
      begin
         if (vld[lun] && hold[lun] != init)
            st = `ST_CONFLICT;
         else
         begin
            vld[lun] = 1'b1;
            hold[lun] = init;
            tpf[lun] = b1[4];
            tpid[lun] = b1[3:1];
         end
      end
      else if (vld[lun] && usr != init && op != `OP_INQUIRY && op != `OP_REQ_SENSE
               && !(op == `OP_MEDIUM_LOCK && !b4[0]))
         st = `ST_CONFLICT;
      for (int i = 0; i < 8; i++)
         ev[i] = vld[i];
      xfer(1'b1, `OFS_CDB_LO, {b2 ^ 8'h5A, b2, b1, op}, q);
      xfer(1'b1, `OFS_CDB_HI, {13'h0, init[2:0], 8'h00, b4}, q);
      xfer(1'b1, `OFS_GO, $random(seed), q);
      xfer(1'b0, `OFS_RESULT, 32'h0, q);
      chk("result", q, {15'h0, 1'b1, 4'h0, sk[3:0], st[7:0]});
      chk("reserved", {24'h0, reserved}, {24'h0, ev});
   endtask

   // ------------
   // Main sequence
   // ------------
   initial
   begin
      logic [31:0] q;
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      xfer(1'b0, `OFS_STATE, 32'h0, q);
      chk("state", q, 32'h00FF_0000);
      xfer(1'b1, 8'h40, 32'hFFFF_FFFF, q);
      xfer(1'b0, 8'h40, 32'h0, q);
      chk("unmapped", q, 32'h0);
      xfer(1'b0, `OFS_CTRL, 32'h0, q);
      chk("ctrl", q, `RST_CTRL);
      for (int i = 0; i < 8; i++)
         do_cmd(i, `OP_INQUIRY, 8'h00, 8'h00, 8'h00);
      do_cmd(1, `OP_RESERVE, 8'h40, 8'h33, 8'h00);
      do_cmd(3, `OP_RESERVE, 8'h40, 8'h00, 8'h00);
      do_cmd(1, `OP_RESERVE, 8'h40, 8'h00, 8'h00);
      foreach (ops[k])
         do_cmd(3, ops[k], 8'h40, 8'h00, 8'h00);
      do_cmd(3, `OP_MEDIUM_LOCK, 8'h40, 8'h00, 8'h01);
      do_cmd(1, `OP_RELEASE, 8'h41, 8'h77, 8'h00);
      xfer(1'b1, `OFS_CTRL, 32'h0, q);
      ext_en = 1'b0;
      do_cmd(1, `OP_RELEASE, 8'h41, 8'h77, 8'h00);
      xfer(1'b1, `OFS_CTRL, 32'h1, q);
      ext_en = 1'b1;
      do_cmd(1, `OP_RELEASE, 8'h40, 8'hEE, 8'h00);
      do_cmd(1, `OP_RESERVE, 8'h9A, 8'h00, 8'h00);
      do_cmd(5, 8'h08, 8'h80, 8'h00, 8'h00);
      do_cmd(1, `OP_RELEASE, 8'h80, 8'h00, 8'h00);
      do_cmd(1, `OP_RELEASE, 8'h9C, 8'h00, 8'h00);
      do_cmd(1, `OP_RELEASE, 8'h9A, 8'h00, 8'h00);
      do_cmd(2, `OP_RESERVE, 8'h21, 8'h00, 8'h00);
      $display("Test directed done");
      do_cmd(6, `OP_RESERVE, 8'hE0, 8'h00, 8'h00);
      @(posedge clk);
      bdr <= 1'b1;
      repeat (8) @(posedge clk);
      bdr <= 1'b0;
      for (int i = 0; i < 8; i++)
      begin
         vld[i] = 1'b0;
         ua[i] = 1'b1;
      end
      chk("bus reset", {24'h0, reserved}, 32'h0);
      xfer(1'b0, `OFS_STATE, 32'h0, q);
      chk("state", q, 32'h00FF_0000);
      $display("Test bus reset done");
      rnd_ce <= 1'b1;
      for (int n = 0; n < 300; n++)
         do_cmd($random(seed) & 7, ops[$unsigned($random(seed)) % 6],
                $random(seed), $random(seed), $random(seed));
      rnd_ce <= 1'b0;
      $display("Test random done");
      close_out();
   end
endmodule

`default_nettype wire
